// ==== rtl/pio_pkg.sv ====
// constants for the three parallel ports and the carrier modulator
package pio_pkg;
    // register addresses on the cpu special-function bus
    localparam logic [7:0] PIO_ADDR_PORT0 = 8'h80;
    localparam logic [7:0] PIO_ADDR_PORT1 = 8'h90;
    localparam logic [7:0] PIO_ADDR_SEL = 8'h9F;
    localparam logic [7:0] PIO_ADDR_PORT2 = 8'hA0;
    localparam logic [7:0] PIO_ADDR_PUD0 = 8'hB2;
    localparam logic [7:0] PIO_ADDR_PUD1 = 8'hB3;
    localparam logic [7:0] PIO_ADDR_PUD2 = 8'hB4;
    // reset values
    localparam logic [7:0] PIO_LATCH_RST = 8'hFF;
    localparam logic [7:0] PIO_SEL_RST = 8'h00;
    localparam logic [7:0] PIO_PUD_RST = 8'h00;
    // port 2 pull-up register: implemented bits and the reset-pin bit
    localparam logic [7:0] PIO_PUD2_MASK = 8'h27;
    localparam int PIO_PUD2_RSTPIN_BIT = 5;
    // port 2 bit that is write only
    localparam int PIO_P2_WO_BIT = 3;
    // carrier enable position in the chip configuration byte
    localparam int PIO_CFG_CARRIER_BIT = 4;
    // carrier pin-select bit positions
    localparam int PIO_SEL_P1_6 = 7;
    localparam int PIO_SEL_P1_5 = 6;
    localparam int PIO_SEL_P1_4 = 5;
    localparam int PIO_SEL_P1_1 = 4;
    localparam int PIO_SEL_P0_2 = 3;
    localparam int PIO_SEL_P0_7 = 2;
    localparam int PIO_SEL_P0_5 = 1;
    localparam int PIO_SEL_P0_3 = 0;
    // carrier timing
    localparam int PIO_CLK_HZ = 100_000_000;
    localparam int PIO_CARRIER_HZ = 38_000;
    localparam int PIO_CARRIER_HALF_CYC = (PIO_CLK_HZ + PIO_CARRIER_HZ) / (2 * PIO_CARRIER_HZ);
endpackage

// ==== rtl/pio_ports.sv ====
// two 8-bit parallel ports and a four-pin port 2, with pull-up control and 38 kHz carrier
//
// How it works
// R01 - three bit-addressable port latches at 0x80, 0x90 and 0xA0
// R02 - an enabled peripheral owns its pin; the port latch no longer drives it
// R03 - each pin has a weak pull-up, on after reset; off makes it open drain
// R04 - each latch bit captures bus data on a write strobe to its port
// R05 - a latch read returns the stored latch bits, not the pins
// R06 - a pin read returns the synchronised pin levels
// R07 - software writes one to a latch before using that pin as input
// R08 - pull-up on: zero drives low, one lets the pull-up hold high
// R09 - pull-up off: one releases the pin, zero pulls it low
// R10 - a modulated pin is driven with latch xor the 38 kHz square wave
// R11 - configuration bit 4 gates all modulation; clear means no pin modulated
// R12 - pin-select register 0x9F enables modulation on eight fixed pins
// R13 - 0xB2 and 0xB3 bit n set disables the pull-up of pin n
// R14 - 0xB4 bit 5 for reset pin, bits 2..0 for P2; others reserved zero
// R15 - pin-select and pull-up registers take whole-byte access only
// R16 - every port latch bit resets to one
// R17 - software keeps the latch at one while a pin serves a peripheral
// R18 - port 2 bit 3 is write only; reads do not show its pin
// R19 - read-modify-write takes the latch path, plain reads the pin path
`timescale 1ns/10ps

module pio_ports
    import pio_pkg::*;
#(
    parameter int CARRIER_HALF = PIO_CARRIER_HALF_CYC
)
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // cpu byte access to special-function registers
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic i_sfr_rmw,
    output logic o_sfr_hit,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_rvalid,
    // cpu bit write
    input wire logic [7:0] i_bit_addr,
    input wire logic i_bit_wdata,
    input wire logic i_bit_wr,
    // chip configuration byte
    input wire logic [7:0] i_cfg_byte,
    // port 0 pins and peripheral hand-over
    input wire logic [7:0] i_p0_pin,
    output logic [7:0] o_p0_out,
    output logic [7:0] o_p0_oe,
    output logic [7:0] o_p0_pu_en,
    input wire logic [7:0] i_p0_alt_en,
    input wire logic [7:0] i_p0_alt_out,
    input wire logic [7:0] i_p0_alt_oe,
    output logic [7:0] o_p0_level,
    // port 1 pins and peripheral hand-over
    input wire logic [7:0] i_p1_pin,
    output logic [7:0] o_p1_out,
    output logic [7:0] o_p1_oe,
    output logic [7:0] o_p1_pu_en,
    input wire logic [7:0] i_p1_alt_en,
    input wire logic [7:0] i_p1_alt_out,
    input wire logic [7:0] i_p1_alt_oe,
    output logic [7:0] o_p1_level,
    // port 2 pins (four exist) and peripheral hand-over
    input wire logic [3:0] i_p2_pin,
    output logic [3:0] o_p2_out,
    output logic [3:0] o_p2_oe,
    output logic [3:0] o_p2_pu_en,
    input wire logic [3:0] i_p2_alt_en,
    input wire logic [3:0] i_p2_alt_out,
    input wire logic [3:0] i_p2_alt_oe,
    output logic [3:0] o_p2_level,
    // reset pin pull-up control
    output logic o_rstpin_pu_en
);

    localparam int PIN_W = 20;
    localparam int CNT_W = $clog2(CARRIER_HALF + 1);

    logic [7:0] latch0_q;
    logic [7:0] latch1_q;
    logic [7:0] latch2_q;
    logic [7:0] sel_q;
    logic [7:0] pud0_q;
    logic [7:0] pud1_q;
    logic [7:0] pud2_q;
    logic [PIN_W-1:0] sync1_q;
    logic [PIN_W-1:0] sync2_q;
    logic [PIN_W-1:0] sync3_q;
    logic [PIN_W-1:0] level_q;
    logic [CNT_W-1:0] cnt_q;
    logic carrier_q;
    logic car_d_q;
    logic [CNT_W-1:0] hp_q;
    logic tick;
    logic carrier_on;
    logic [7:0] mod0;
    logic [7:0] mod1;
    logic [7:0] lvl0;
    logic [7:0] lvl1;
    logic [7:0] lvl2;
    logic [15:0] drv0;
    logic [15:0] drv1;
    logic [15:0] drv2;
    logic [7:0] read_mux;

    // level put out by the latch path, and the drive that follows from it
    function automatic logic [15:0] pio_drive(input logic [7:0] lvl, input logic [7:0] alt_en,
                                              input logic [7:0] alt_out, input logic [7:0] alt_oe);
        logic [7:0] out;
        logic [7:0] oe;
        out = (alt_en & alt_out);
        oe = (alt_en & alt_oe) | (~alt_en & ~lvl);
        return {out, oe};
    endfunction

    // true when a bit address falls in the given port's bit range
    function automatic logic pio_bit_hit(input logic [7:0] baddr, input logic [7:0] port);
        return baddr[7:3] == port[7:3];
    endfunction

    // byte write or single-bit write into one port latch
    function automatic logic [7:0] pio_latch_next(input logic [7:0] cur, input logic [7:0] port);
        logic [7:0] nxt;
        nxt = cur;
        if (i_sfr_wr && i_sfr_addr == port)
        begin
            nxt = i_sfr_wdata;
        end
        if (i_bit_wr && pio_bit_hit(i_bit_addr, port))
        begin
            nxt[i_bit_addr[2:0]] = i_bit_wdata;
        end
        return nxt;
    endfunction

    // port latches, all ones after reset
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            latch0_q <= PIO_LATCH_RST; // see R16
            latch1_q <= PIO_LATCH_RST; // see R16
            latch2_q <= PIO_LATCH_RST; // see R16
        end
        else
        begin
            latch0_q <= pio_latch_next(latch0_q, PIO_ADDR_PORT0); // see R04
            latch1_q <= pio_latch_next(latch1_q, PIO_ADDR_PORT1); // see R04
            latch2_q <= pio_latch_next(latch2_q, PIO_ADDR_PORT2); // see R01
        end
    end

    // byte-only configuration registers; bit writes never reach them
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            sel_q <= PIO_SEL_RST;
            pud0_q <= PIO_PUD_RST;
            pud1_q <= PIO_PUD_RST;
            pud2_q <= PIO_PUD_RST;
        end
        else if (i_sfr_wr)
        begin
            case (i_sfr_addr) // see R15
                PIO_ADDR_SEL: sel_q <= i_sfr_wdata; // see R12
                PIO_ADDR_PUD0: pud0_q <= i_sfr_wdata; // see R13
                PIO_ADDR_PUD1: pud1_q <= i_sfr_wdata; // see R13
                PIO_ADDR_PUD2: pud2_q <= i_sfr_wdata & PIO_PUD2_MASK; // see R14
                default: ;
            endcase
        end
    end

    // pin synchroniser: level goes high once stages two and three are both high, low as soon as they differ
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            sync1_q <= '1;
            sync2_q <= '1;
            sync3_q <= '1;
            level_q <= '1;
        end
        else
        begin
            sync1_q <= {i_p2_pin, i_p1_pin, i_p0_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            level_q <= (sync2_q & sync3_q) | (level_q & ~(sync2_q ^ sync3_q));
        end
    end

    // carrier divider: one tick per half period
    assign tick = (cnt_q == CNT_W'(CARRIER_HALF - 1));

    // carrier counter and square wave
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            cnt_q <= '0;
            carrier_q <= 1'b0;
        end
        else if (tick)
        begin
            cnt_q <= '0;
            carrier_q <= ~carrier_q; // see R10
        end
        else
        begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // modulation masks per pin, gated by the global enable
    assign carrier_on = i_cfg_byte[PIO_CFG_CARRIER_BIT] & carrier_q; // see R11
    assign mod0 = {sel_q[PIO_SEL_P0_7], 1'b0, sel_q[PIO_SEL_P0_5], 1'b0,
                   sel_q[PIO_SEL_P0_3], sel_q[PIO_SEL_P0_2], 2'b00}; // see R12
    assign mod1 = {1'b0, sel_q[PIO_SEL_P1_6], sel_q[PIO_SEL_P1_5], sel_q[PIO_SEL_P1_4],
                   2'b00, sel_q[PIO_SEL_P1_1], 1'b0}; // see R12

    // level each pin should show on the latch path
    assign lvl0 = latch0_q ^ (mod0 & {8{carrier_on}}); // see R10
    assign lvl1 = latch1_q ^ (mod1 & {8{carrier_on}}); // see R10
    assign lvl2 = latch2_q;

    // pin drive: peripheral first, else pull low on a zero level
    assign drv0 = pio_drive(lvl0, i_p0_alt_en, i_p0_alt_out, i_p0_alt_oe); // see R02
    assign drv1 = pio_drive(lvl1, i_p1_alt_en, i_p1_alt_out, i_p1_alt_oe); // see R02
    assign drv2 = pio_drive(lvl2, {4'h0, i_p2_alt_en}, {4'h0, i_p2_alt_out}, {4'h0, i_p2_alt_oe});

    // registered pin drive and pull-up enables
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            o_p0_out <= '0;
            o_p0_oe <= '0;
            o_p1_out <= '0;
            o_p1_oe <= '0;
            o_p2_out <= '0;
            o_p2_oe <= '0;
            o_p0_pu_en <= '1;
            o_p1_pu_en <= '1;
            o_p2_pu_en <= '1;
            o_rstpin_pu_en <= 1'b1;
        end
        else
        begin
            o_p0_out <= drv0[15:8];
            o_p0_oe <= drv0[7:0]; // see R08
            o_p1_out <= drv1[15:8];
            o_p1_oe <= drv1[7:0]; // see R09
            o_p2_out <= drv2[11:8];
            o_p2_oe <= drv2[3:0];
            o_p0_pu_en <= ~pud0_q; // see R03
            o_p1_pu_en <= ~pud1_q; // see R03
            o_p2_pu_en <= {1'b1, ~pud2_q[2:0]}; // see R14
            o_rstpin_pu_en <= ~pud2_q[PIO_PUD2_RSTPIN_BIT]; // see R14
        end
    end

    // synchronised levels handed to peripherals
    assign o_p0_level = level_q[7:0];
    assign o_p1_level = level_q[15:8];
    assign o_p2_level = level_q[19:16];

    // address decode for the byte bus
    always_comb
    begin
        o_sfr_hit = 1'b1;
        read_mux = 8'h00;
        case (i_sfr_addr)
            PIO_ADDR_PORT0: read_mux = i_sfr_rmw ? latch0_q : level_q[7:0]; // see R05
            PIO_ADDR_PORT1: read_mux = i_sfr_rmw ? latch1_q : level_q[15:8]; // see R06
            PIO_ADDR_PORT2: read_mux = i_sfr_rmw ? latch2_q :
                {latch2_q[7:PIO_P2_WO_BIT], level_q[18:16]}; // see R18
            PIO_ADDR_SEL: read_mux = sel_q;
            PIO_ADDR_PUD0: read_mux = pud0_q;
            PIO_ADDR_PUD1: read_mux = pud1_q;
            PIO_ADDR_PUD2: read_mux = pud2_q;
            default: o_sfr_hit = 1'b0;
        endcase
    end

    // read data registered one cycle after the read strobe
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            o_sfr_rdata <= 8'h00;
            o_sfr_rvalid <= 1'b0;
        end
        else
        begin
            o_sfr_rvalid <= i_sfr_rd;
            if (i_sfr_rd)
            begin
                o_sfr_rdata <= read_mux; // see R19
            end
        end
    end

    // checks on latch capture, read paths, drive and carrier
    latch_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R04
        (i_sfr_wr && i_sfr_addr == PIO_ADDR_PORT0 && !i_bit_wr) |=> latch0_q == $past(i_sfr_wdata))
        else $error("port 0 latch missed a byte write");

    bit_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R01
        (i_bit_wr && !i_sfr_wr && i_bit_addr[7:3] == PIO_ADDR_PORT1[7:3])
        |=> latch1_q[$past(i_bit_addr[2:0])] == $past(i_bit_wdata))
        else $error("port 1 bit write not captured");

    read_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R05
        (i_sfr_rd && i_sfr_rmw && i_sfr_addr == PIO_ADDR_PORT1)
        |=> o_sfr_rvalid && o_sfr_rdata == $past(latch1_q))
        else $error("latch read returned wrong data");

    read_pin_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R06
        (i_sfr_rd && !i_sfr_rmw && i_sfr_addr == PIO_ADDR_PORT0)
        |=> o_sfr_rdata == $past(level_q[7:0]))
        else $error("pin read returned wrong data");

    p2_write_only_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R18
        (i_sfr_rd && !i_sfr_rmw && i_sfr_addr == PIO_ADDR_PORT2)
        |=> o_sfr_rdata[PIO_P2_WO_BIT] == $past(latch2_q[PIO_P2_WO_BIT]))
        else $error("port 2 bit 3 read shows pin");

    byte_only_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R15
        (i_bit_wr && !i_sfr_wr) |=> $stable(sel_q) && $stable(pud0_q) && $stable(pud2_q))
        else $error("bit write reached a byte-only register");

    pullup_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R13
        (i_sfr_wr && i_sfr_addr == PIO_ADDR_PUD1) |=> ##1 o_p1_pu_en == ~$past(i_sfr_wdata, 2))
        else $error("port 1 pull-up does not follow its register");

    alt_owner_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R02
        ##1 (o_p0_oe & $past(i_p0_alt_en)) == $past(i_p0_alt_oe & i_p0_alt_en))
        else $error("peripheral pin not driven by peripheral");

    carrier_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R11
        !i_cfg_byte[PIO_CFG_CARRIER_BIT] |=> ((o_p0_oe ^ ~$past(latch0_q)) & ~$past(i_p0_alt_en)) == 8'h00)
        else $error("pin modulated while carrier disabled");

    carrier_mod_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R10
        (sel_q[PIO_SEL_P1_6] && i_cfg_byte[PIO_CFG_CARRIER_BIT] && !i_p1_alt_en[6])
        |=> o_p1_oe[6] == ~($past(latch1_q[6]) ^ $past(carrier_q)))
        else $error("modulated pin not latch xor carrier");

    // helper: cycles since the carrier last moved, counted apart from the divider
    always_ff @(posedge i_core_clk)
    begin
        car_d_q <= carrier_q;
        hp_q <= !i_rst_n ? '0 : (carrier_q != car_d_q) ? CNT_W'(1) : hp_q + CNT_W'(hp_q != CNT_W'(CARRIER_HALF));
    end

    carrier_period_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see R10
        (carrier_q != car_d_q) |-> hp_q == CNT_W'(CARRIER_HALF))
        else $error("carrier half period out of range");

    latch_reset_a: assert property (@(posedge i_core_clk) // see R16
        !i_rst_n |=> latch0_q == PIO_LATCH_RST && latch2_q == PIO_LATCH_RST && o_p0_pu_en == 8'hFF)
        else $error("latch or pull-up wrong after reset");

endmodule

// ==== test/pio_pin_model.sv ====
// pad resolution and external devices for the general pins
`timescale 1ns/10ps

module pio_pin_model #(
    parameter int W = 20
)
(
    // clock
    input wire logic i_clk,
    // pad controls from the ports
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_oe,
    input wire logic [W-1:0] i_pu_en,
    // external device drive
    input wire logic [W-1:0] i_ext_en,
    input wire logic [W-1:0] i_ext_val,
    // resolved pad level
    output logic [W-1:0] o_pin
);
    logic [W-1:0] float_q = '0;

    // an undriven pad without pull-up wanders every cycle
    always_ff @(posedge i_clk)
    begin
        float_q <= ~float_q;
    end

    // port drive wins, then the external device, then the weak pull-up
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (i_oe[i])
                o_pin[i] = i_out[i];
            else if (i_ext_en[i])
                o_pin[i] = i_ext_val[i];
            else
                o_pin[i] = i_pu_en[i] ? 1'b1 : float_q[i];
        end
    end
endmodule

// ==== test/pio_ports_bench.sv ====
// self-checking bench for the parallel ports
`timescale 1ns/10ps

module pio_ports_bench import pio_pkg::*;;
    localparam logic [7:0] AD [8] = '{PIO_ADDR_PORT0, PIO_ADDR_PORT1, PIO_ADDR_SEL, PIO_ADDR_PORT2,
        PIO_ADDR_PUD0, PIO_ADDR_PUD1, PIO_ADDR_PUD2, 8'hA5};
    localparam logic [7:0] RV [8] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int MP [8] = '{3, 5, 7, 2, 9, 12, 13, 14};
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rmw = 1'b0, bwd = 1'b0, bwr = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, baddr = 8'h00, cfg = 8'h00;
    logic [19:0] aen = '0, aout = '0, aoe = '0, xen = '0, xval = '0;
    logic [19:0] pin, pout, poe, ppu, plvl, apick;
    logic hit, rvalid, rpu;
    logic [7:0] rdata, a, b, c, e, h;
    logic [7:0] v [8];
    logic [7:0] exp_q [$];
    logic [15:0] prv;
    int n_errors = 0, n_checks = 0, tg, tot;

    pio_ports #(.CARRIER_HALF(10)) dut_u (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_rmw(rmw), .o_sfr_hit(hit), .o_sfr_rdata(rdata), .o_sfr_rvalid(rvalid),
        .i_bit_addr(baddr), .i_bit_wdata(bwd), .i_bit_wr(bwr), .i_cfg_byte(cfg),
        .i_p0_pin(pin[7:0]), .o_p0_out(pout[7:0]), .o_p0_oe(poe[7:0]), .o_p0_pu_en(ppu[7:0]),
        .i_p0_alt_en(aen[7:0]), .i_p0_alt_out(aout[7:0]), .i_p0_alt_oe(aoe[7:0]), .o_p0_level(plvl[7:0]),
        .i_p1_pin(pin[15:8]), .o_p1_out(pout[15:8]), .o_p1_oe(poe[15:8]), .o_p1_pu_en(ppu[15:8]),
        .i_p1_alt_en(aen[15:8]), .i_p1_alt_out(aout[15:8]), .i_p1_alt_oe(aoe[15:8]),
        .o_p1_level(plvl[15:8]), .i_p2_pin(pin[19:16]), .o_p2_out(pout[19:16]), .o_p2_oe(poe[19:16]),
        .o_p2_pu_en(ppu[19:16]), .i_p2_alt_en(aen[19:16]), .i_p2_alt_out(aout[19:16]),
        .i_p2_alt_oe(aoe[19:16]), .o_p2_level(plvl[19:16]), .o_rstpin_pu_en(rpu));

    pio_pin_model #(.W(20)) pads_u (.i_clk(clk), .i_out(pout), .i_oe(poe), .i_pu_en(ppu),
        .i_ext_en(xen), .i_ext_val(xval), .o_pin(pin));

    // clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [19:0] ex, input logic [19:0] got);
        n_checks++;
        if (got !== ex)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic idle(input int n);
        wr = 1'b0;
        rd = 1'b0;
        bwr = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
        rd = 1'b0;
        bwr = 1'b0;
        wr = 1'b1;
        addr = ad;
        wdata = d;
        @(posedge clk);
        #1;
    endtask

    task automatic bit_wr(input logic [7:0] ad, input logic d);
        rd = 1'b0;
        wr = 1'b0;
        bwr = 1'b1;
        baddr = ad;
        bwd = d;
        @(posedge clk);
        #1;
    endtask

    // queue the expected byte, then issue the read
    task automatic rd_reg(input logic [7:0] ad, input logic m, input logic [7:0] ex);
        wr = 1'b0;
        bwr = 1'b0;
        rd = 1'b1;
        rmw = m;
        addr = ad;
        exp_q.push_back(ex);
        @(posedge clk);
        chk("hit", 20'(ad != 8'hA5), 20'(hit));
        #1;
    endtask

    // count oe changes on the two full ports over forty cycles
    task automatic count_oe(input int bitpos);
        tg = 0;
        tot = 0;
        prv = poe[15:0];
        repeat (40)
        begin
            @(posedge clk);
            #1;
            tot += $countones(poe[15:0] ^ prv);
            if (bitpos >= 0 && poe[bitpos] !== prv[bitpos])
                tg++;
            prv = poe[15:0];
        end
    endtask

    // take the oldest expected byte whenever read data is valid
    always @(negedge clk)
    begin
        if (rst_n && rvalid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("rvalid", 20'h0, 20'h1);
            else
                chk("rdata", 20'(exp_q.pop_front()), 20'(rdata));
        end
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'h8e7441fb));
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk("pu_en", 20'hFFFFF, ppu);
        chk("oe", 20'h0, poe);
        chk("rstpu", 20'h1, 20'(rpu));
        for (int i = 0; i < 8; i++)
            rd_reg(AD[i], 1'b1, RV[i]);
        // back-to-back writes, then read back
        for (int i = 0; i < 7; i++)
        begin
            v[i] = 8'($urandom);
            wr_reg(AD[i], (i == 6) ? (v[i] & PIO_PUD2_MASK) : v[i]);
        end
        for (int i = 0; i < 7; i++)
            rd_reg(AD[i], 1'b1, (i == 6) ? (v[i] & PIO_PUD2_MASK) : v[i]);
        // pull-ups on: latch sets the level
        wr_reg(PIO_ADDR_PUD0, 8'h00);
        wr_reg(PIO_ADDR_PUD1, 8'h00);
        a = 8'($urandom);
        b = 8'($urandom);
        wr_reg(PIO_ADDR_PORT0, a);
        wr_reg(PIO_ADDR_PORT1, b);
        idle(6);
        chk("oe", {4'h0, ~b, ~a}, {4'h0, poe[15:0]});
        rd_reg(PIO_ADDR_PORT0, 1'b0, a);
        // inputs after writing ones: pin path differs from latch path
        wr_reg(PIO_ADDR_PORT0, 8'hFF);
        c = 8'($urandom);
        xen[7:0] = 8'hFF;
        xval[7:0] = c;
        idle(6);
        chk("level0", {12'h000, c}, {12'h000, plvl[7:0]});
        rd_reg(PIO_ADDR_PORT0, 1'b0, c);
        rd_reg(PIO_ADDR_PORT0, 1'b1, 8'hFF);
        // open drain: ones release, zeros pull low
        wr_reg(PIO_ADDR_PUD0, 8'hFF);
        e = 8'($urandom);
        wr_reg(PIO_ADDR_PORT0, e);
        idle(6);
        chk("pu_en0", 20'h0, 20'(ppu[7:0]));
        rd_reg(PIO_ADDR_PORT0, 1'b0, e & c);
        // pull-up registers of port 1 and port 2
        a = 8'($urandom);
        wr_reg(PIO_ADDR_PUD1, a);
        wr_reg(PIO_ADDR_PUD2, 8'h00);
        idle(3);
        chk("pu_en1", {12'h000, ~a}, 20'(ppu[15:8]));
        chk("pu_en2", 20'hF, 20'(ppu[19:16]));
        wr_reg(PIO_ADDR_PUD2, PIO_PUD2_MASK);
        idle(3);
        chk("pu_en2", 20'h8, 20'(ppu[19:16]));
        chk("rstpu", 20'h0, 20'(rpu));
        wr_reg(PIO_ADDR_PUD2, 8'h00);
        // port 2: bit 3 is write only, upper bits come from the latch
        h = 8'($urandom) | 8'h09;
        wr_reg(PIO_ADDR_PORT2, h);
        xen[19:16] = 4'h9;
        xval[19:16] = 4'h0;
        idle(6);
        chk("level2", {16'h0000, 1'b0, h[2:1], 1'b0}, {16'h0000, plvl[19:16]});
        rd_reg(PIO_ADDR_PORT2, 1'b0, {h[7:3], h[2:1], 1'b0});
        rd_reg(PIO_ADDR_PORT2, 1'b1, h);
        // bit writes reach ports only
        bit_wr(8'h83, 1'b0);
        bit_wr(8'h96, ~b[6]);
        b[6] = ~b[6];
        bit_wr(8'hB2, 1'b0);
        bit_wr(8'h9F, ~v[2][7]);
        rd_reg(PIO_ADDR_PORT0, 1'b1, e & 8'hF7);
        rd_reg(PIO_ADDR_PUD0, 1'b1, 8'hFF);
        rd_reg(PIO_ADDR_SEL, 1'b1, v[2]);
        rd_reg(PIO_ADDR_PORT1, 1'b1, b);
        // peripherals take their pins, their latch bits set to one first
        apick = 20'($urandom);
        wr_reg(PIO_ADDR_PORT0, (e & 8'hF7) | apick[7:0]);
        wr_reg(PIO_ADDR_PORT1, b | apick[15:8]);
        wr_reg(PIO_ADDR_PORT2, h | {4'h0, apick[19:16]});
        aen = apick;
        aout = 20'($urandom);
        aoe = 20'($urandom);
        idle(3);
        chk("alt_oe", (aen & aoe) | (~aen & ~{h[3:0], b, e & 8'hF7}), poe);
        chk("alt_out", aen & aoe & aout, pout & aen & aoe);
        aen = '0;
        // carrier on each selectable pin alone
        cfg = 8'($urandom) | 8'h10;
        for (int k = 0; k < 8; k++)
        begin
            wr_reg(PIO_ADDR_SEL, 8'(1 << k));
            idle(3);
            count_oe(MP[k]);
            chk("toggles", 20'd4, 20'(tg));
            chk("others", 20'(tg), 20'(tot));
        end
        // global gate off: nothing moves
        wr_reg(PIO_ADDR_SEL, 8'hFF);
        cfg = cfg & 8'hEF;
        idle(3);
        count_oe(-1);
        chk("gated", 20'h0, 20'(tot));
        for (int i = 0; i < 20 && exp_q.size() > 0; i++)
            idle(1);
        if (exp_q.size() > 0)
            n_errors++;
        finish_test();
    end
endmodule
